/* common/smrp_pkg.sv */
/*
  Constants and types for the serial memory read path.
  Assumes a two-wire bus master outside and a 2K byte array inside.
*/
package smrp_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 2048;
  localparam int FIFO_DEPTH = 32;
  localparam int PAGE_W = 3;
  localparam int DEV_W = 4;
  localparam int LOW_W = 8;

  // ****************************************
  // Slave address byte fields
  // ****************************************
  localparam int RW_BIT = 0;
  localparam int PAGE_LSB = 1;
  localparam int PAGE_MSB = 3;
  localparam int DEV_LSB = 4;
  localparam int DEV_MSB = 7;
  localparam int BYTE_MSB = 7;

  // ****************************************
  // Counts and reset values
  // ****************************************
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [10:0] ADDR_STEP = 11'h001;
  localparam logic [10:0] ADDR_RESET = 11'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Pending array write: location and byte
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } smrp_wr_type;

  // Bus sequencer states
  typedef enum logic [2:0] {
    st_idle, st_rx, st_dec, st_ack, st_tx, st_mack
  } smrp_state_type;

  // Meaning of the next received byte
  typedef enum logic [1:0] {
    ph_slave, ph_word, ph_data
  } smrp_phase_type;
endpackage

/* rtl/smrp_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/10ps
module smrp_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire empty = (wp == rp);
  wire do_wr = i_in_valid && !full;
  wire do_rd = i_out_ready && !empty;

  // Flags straight from the pointers, so full really blocks the source
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = store[rp[AW-1:0]];

  // Storage
  always_ff @(posedge i_mclk) begin
    if (do_wr) begin
      store[wp[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers, one extra bit tells full from empty
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= wp + (AW+1)'(do_wr);
      rp <= rp + (AW+1)'(do_rd);
    end
  end
endmodule // smrp_fifo

/* rtl/smrp_top.sv */
/*
  Two-wire slave serial memory, read path with the write preamble
  that loads the address latch. Holds the 2K byte array itself.
  Assumes SCL and SDA arrive from pins, far slower than i_mclk, and
  that the pad turns o_sda_oe into an open-drain pull-down.
*/
`timescale 1ns/10ps
module smrp_top #(
  // Device type code; value is arbitrary
  parameter logic [3:0] P_DEV_TYPE = 4'h5
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_busy
);
  // ****************************************
  // Pin synchronisers and condition detect
  // ****************************************
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic sda_d;

  // Three flops per pin; the second and third feed the edge and condition logic
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // Edges and bus conditions, SDA moving while SCL stays high
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire scl_high = scl_s && scl_d;
  wire bus_start = scl_high && sda_d && !sda_s;
  wire bus_stop = scl_high && !sda_d && sda_s;

  // ****************************************
  // State
  // ****************************************
  smrp_pkg::smrp_state_type state;
  smrp_pkg::smrp_state_type next_state;
  smrp_pkg::smrp_phase_type phase;
  smrp_pkg::smrp_phase_type next_phase;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [10:0] addr;
  logic [10:0] next_addr;
  logic rd;
  logic next_rd;
  logic next_oe;
  logic fetch;
  logic push;

  // ****************************************
  // Byte array and write queue
  // ****************************************
  logic [7:0] mem [smrp_pkg::MEM_DEPTH];
  smrp_pkg::smrp_wr_type wr_in;
  smrp_pkg::smrp_wr_type wr_out;
  logic wr_ready;
  logic wr_valid;

  // Read port is asynchronous so the byte is ready on the fetch edge
  wire [7:0] mem_byte = mem[addr];
  wire [10:0] addr_inc = addr + smrp_pkg::ADDR_STEP;
  wire dev_hit = shift[smrp_pkg::DEV_MSB:smrp_pkg::DEV_LSB] == P_DEV_TYPE;
  wire [2:0] page_sel = shift[smrp_pkg::PAGE_MSB:smrp_pkg::PAGE_LSB];

  assign wr_in = {addr, shift};

  // Drain stalls on a fetch cycle, so read and write never share a cycle
  wire drain = wr_valid && !fetch;

  smrp_fifo #(
    .WIDTH($bits(smrp_pkg::smrp_wr_type)),
    .DEPTH(smrp_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_in_valid(push),
    .o_in_ready(wr_ready),
    .i_in_data(wr_in),
    .o_out_valid(wr_valid),
    .i_out_ready(!fetch),
    .o_out_data(wr_out)
  );

  // Array write from the queue; a few cycles late, far inside one SCL bit
  always_ff @(posedge i_mclk) begin
    if (drain) begin
      mem[wr_out.addr] <= wr_out.data;
    end
  end

  // ****************************************
  // Bus sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cnt = cnt;
    next_shift = shift;
    next_addr = addr;
    next_rd = rd;
    next_oe = o_sda_oe;
    fetch = 1'b0;
    push = 1'b0;
    if (bus_start) begin
      next_state = smrp_pkg::st_rx;
      next_phase = smrp_pkg::ph_slave;
      next_cnt = smrp_pkg::BIT_FIRST;
      next_oe = 1'b0;
    end else if (bus_stop) begin
      next_state = smrp_pkg::st_idle;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        smrp_pkg::st_idle: begin
          next_oe = 1'b0;
        end
        smrp_pkg::st_rx: begin
          if (scl_rise) begin
            next_shift = {shift[smrp_pkg::BYTE_MSB-1:0], sda_s};
            next_cnt = cnt + smrp_pkg::BIT_STEP;
            if (cnt == smrp_pkg::BIT_LAST) begin
              next_state = smrp_pkg::st_dec;
            end
          end
        end
        smrp_pkg::st_dec: begin
          if (scl_fall) begin
            unique case (phase)
              smrp_pkg::ph_slave: begin
                if (dev_hit) begin
                  // page bits over latched low byte
                  next_addr = {page_sel, addr[smrp_pkg::LOW_W-1:0]};
                  next_rd = shift[smrp_pkg::RW_BIT];
                  next_phase = smrp_pkg::ph_word;
                  next_oe = 1'b1;
                  next_state = smrp_pkg::st_ack;
                end else begin
                  next_state = smrp_pkg::st_idle;
                end
              end
              smrp_pkg::ph_word: begin
                next_addr = {addr[smrp_pkg::ADDR_W-1:smrp_pkg::LOW_W], shift};
                next_phase = smrp_pkg::ph_data;
                next_oe = 1'b1;
                next_state = smrp_pkg::st_ack;
              end
              smrp_pkg::ph_data: begin
                if (wr_ready) begin
                  push = 1'b1;
                  next_addr = addr_inc;
                  next_oe = 1'b1;
                  next_state = smrp_pkg::st_ack;
                end else begin
                  // Queue full: withhold ack, the master may retry
                  next_state = smrp_pkg::st_idle;
                end
              end
              default: begin
                next_state = smrp_pkg::st_idle;
              end
            endcase
          end
        end
        smrp_pkg::st_ack: begin
          if (scl_fall) begin
            next_cnt = smrp_pkg::BIT_FIRST;
            if (rd) begin
              fetch = 1'b1;
              next_shift = mem_byte;
              next_oe = !mem_byte[smrp_pkg::BYTE_MSB];
              next_addr = addr_inc;
              next_state = smrp_pkg::st_tx;
            end else begin
              next_oe = 1'b0;
              next_state = smrp_pkg::st_rx;
            end
          end
        end
        smrp_pkg::st_tx: begin
          if (scl_fall) begin
            if (cnt == smrp_pkg::BIT_LAST) begin
              // Release for master ack bit
              next_oe = 1'b0;
              next_state = smrp_pkg::st_mack;
            end else begin
              next_shift = {shift[smrp_pkg::BYTE_MSB-1:0], 1'b0};
              next_oe = !shift[smrp_pkg::BYTE_MSB-1];
              next_cnt = cnt + smrp_pkg::BIT_STEP;
            end
          end
        end
        smrp_pkg::st_mack: begin
          if (scl_rise) begin
            if (!sda_s) begin
              next_state = smrp_pkg::st_ack;
            end else begin
              // nack ends read, line stays released
              next_oe = 1'b0;
              next_state = smrp_pkg::st_idle;
            end
          end
        end
        default: begin
          next_state = smrp_pkg::st_idle;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= smrp_pkg::st_idle;
      phase <= smrp_pkg::ph_slave;
      cnt <= smrp_pkg::BIT_FIRST;
      shift <= smrp_pkg::BYTE_RESET;
      addr <= smrp_pkg::ADDR_RESET;
      rd <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cnt <= next_cnt;
      shift <= next_shift;
      addr <= next_addr;
      rd <= next_rd;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open drain: the pad only ever pulls low, data rides on the enable
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_sda_oe <= next_oe;
      o_sda_out <= 1'b0;
      o_busy <= next_state != smrp_pkg::st_idle;
    end
  end
endmodule // smrp_top

/* bench/smrp_monitor.sv */
/*
  Checker for the read path top: bus framing versus data line drive.
  Assumes binding to smrp_top with the bench's slow bus clock.
*/
`timescale 1ns/10ps
module smrp_monitor #(
  parameter logic [3:0] P_DEV_TYPE = 4'h5
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_busy
);
  // ****************************************
  // Bus tracking
  // ****************************************
  logic scl_q, sda_q, first, rd, nk;
  logic [3:0] nb, fc, hc;
  logic [7:0] sh;
  wire rise = i_scl & ~scl_q;
  wire fall = ~i_scl & scl_q;
  wire start = i_scl & scl_q & sda_q & ~i_sda;
  wire slot = rise & (nb == 4'h8);
  wire mine = sh[7:4] == P_DEV_TYPE;
  // Bit count, address byte and nack seen; edge counters fc and hc saturate to stay quiet
  always_ff @(posedge i_mclk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    fc <= fall ? 4'h0 : fc + {3'h0, fc != 4'hf};
    hc <= rise ? 4'h0 : hc + {3'h0, hc != 4'hf};
    if (i_reset | start) begin
      nb <= 4'h0;
      first <= 1'b1;
      rd <= 1'b0;
      nk <= 1'b0;
    end else if (slot) begin
      nb <= 4'h0;
      first <= 1'b0;
      rd <= first ? (sh[0] & mine) : rd;
      nk <= nk | (~first & rd & i_sda);
    end else if (rise) begin
      nb <= nb + 4'h1;
      sh <= {sh[6:0], i_sda};
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  sequence s_start; i_scl && scl_q && sda_q && !i_sda; endsequence
  sequence s_stop; i_scl && scl_q && !sda_q && i_sda; endsequence
  sequence s_addr; slot && first; endsequence
  a_addr_ack: assert property (s_addr and mine |-> o_sda_oe)
    else $error("own address not acknowledged");
  a_foreign_quiet: assert property (s_addr and !mine |-> !o_sda_oe)
    else $error("foreign address acknowledged");
  a_nack_release: assert property (nk |-> !o_sda_oe)
    else $error("data driven after master nack");
  a_oe_after_fall: assert property ($rose(o_sda_oe) |-> fc >= 4'h2 && fc <= 4'h4)
    else $error("drive not launched from clock fall");
  a_high_stable: assert property (i_scl && hc <= 4'h2 |-> $stable(o_sda_oe))
    else $error("data changed while clock high");
  a_start_abort: assert property (s_start |-> ##[2:6] (o_busy && !o_sda_oe))
    else $error("start did not restart sequencer");
  a_stop_idle: assert property (s_stop |-> ##[2:8] (!o_busy && !o_sda_oe))
    else $error("stop did not idle the device");
  a_idle_release: assert property (!o_busy && !$past(o_busy) |-> !o_sda_oe)
    else $error("idle device drives data line");
  a_reset_quiet: assert property ($past(i_reset) |-> !o_busy && !o_sda_oe && !o_sda_out)
    else $error("outputs active after reset");
endmodule // smrp_monitor

bind smrp_top smrp_monitor #(.P_DEV_TYPE(P_DEV_TYPE)) u_monitor (.i_mclk(i_mclk),
  .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_busy(o_busy));

/* bench/smrp_bus_model.sv */
/*
  Two-wire bus master model: 160 ns clock, open-drain data release.
  Assumes the bench ANDs o_sda with the device pull-down.
*/
`timescale 1ns/10ps
module smrp_bus_model (
  input wire logic i_mclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Bus idles released, clock stands high outside frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Quarter bus period; edges land just after mclk so sampling is clean
  task automatic tick();
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic start();
    tick();
    o_sda = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b0;
  endtask
  // Data changes mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    tick();
    o_sda = b;
    tick();
    o_scl = 1'b1;
    tick();
    r = i_sda;
    tick();
    o_scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // read byte; nine low leaves the ninth clock to stop or start
  task automatic fetch(input logic ack, input logic nine, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    if (nine) begin
      bit_io(~ack, r);
    end
  endtask
  task automatic stop();
    tick();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b1;
    tick();
  endtask
endmodule // smrp_bus_model

/* bench/smrp_test.sv */
/*
  Self-checking bench for the read path: writes content, then reads it.
  Assumes the bus model and the bound checker alongside.
*/
`timescale 1ns/10ps
module smrp_test;
  // ****************************************
  // Setup
  // ****************************************
  localparam logic [3:0] DEV = 4'h6; // Device type; value is arbitrary
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic m_scl, m_sda, sda_out, sda_oe, busy, ack;
  logic [7:0] d;
  logic [7:0] pat [4] = '{8'hc1, 8'h3a, 8'h96, 8'h5e};
  int err_count = 0;
  int checks_done = 0;
  // Pulled-up wire, low while either side pulls
  wire sda_w = m_sda & ~(sda_oe & ~sda_out);
  always #10 i_mclk = ~i_mclk;
  smrp_top #(.P_DEV_TYPE(DEV)) DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_scl(m_scl),
    .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_busy(busy));
  smrp_bus_model bm (.i_mclk(i_mclk), .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic snd(input logic [7:0] v);
    bm.send(v, ack);
    chk({7'h0, ack}, 8'h01);
  endtask
  task automatic addr(input logic [2:0] pg, input logic rw);
    bm.start();
    snd({DEV, pg, rw});
  endtask
  // Stop, then a bounded wait for idle
  task automatic fin();
    int n;
    bm.stop();
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge i_mclk);
      n++;
    end
    chk({7'h0, busy}, 8'h00);
    if (busy !== 1'b0) test_done();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Content at 302h, then four bytes from 7FEh across the top
  task automatic t_fill();
    addr(3'h3, 1'b0);
    snd(8'h02);
    snd(8'h4d);
    fin();
    addr(3'h7, 1'b0);
    snd(8'hfe);
    for (int i = 0; i < 4; i++) snd(pat[i]);
    fin();
  endtask
  // Word load, repeated start, ack then nack with stop
  task automatic t_select();
    addr(3'h7, 1'b0);
    snd(8'hfe);
    addr(3'h7, 1'b1);
    bm.fetch(1'b1, 1'b1, d);
    chk(d, pat[0]);
    bm.fetch(1'b0, 1'b1, d);
    chk(d, pat[1]);
    fin();
  endtask
  // Latch wrapped to 000h; nack then start, then stop in ninth clock
  task automatic t_current();
    addr(3'h0, 1'b1);
    bm.fetch(1'b0, 1'b1, d);
    chk(d, pat[2]);
    addr(3'h0, 1'b1);
    bm.fetch(1'b1, 1'b0, d);
    chk(d, pat[3]);
    fin();
  endtask
  // Page bits over latch 02h; start in ninth clock; foreign type refused
  task automatic t_page();
    addr(3'h3, 1'b1);
    bm.fetch(1'b1, 1'b0, d);
    chk(d, 8'h4d);
    bm.start();
    bm.send({~DEV, 3'h3, 1'b1}, ack);
    chk({7'h0, ack}, 8'h00);
    fin();
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge i_mclk);
    #1;
    i_reset = 1'b0;
    repeat (4) @(posedge i_mclk);
    t_fill();
    t_select();
    t_current();
    t_page();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    err_count++;
    test_done();
  end
endmodule // smrp_test
